/* hdl/smr_top.sv */
`timescale 1ns/10ps
`include "smr_params.svh"
module smr_top #(
  parameter int BASE_CYC = `SMR_BASE_CYC
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // apb slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic [31:0]            prdata_out,
  // nonvolatile preload and power state
  input  wire smr_pkg::smr_nvm_type nvm_in,
  input  wire logic              standby_in,
  // comparator, asynchronous
  input  wire logic              below_in,
  // analog controls
  output logic                   det_on_out,
  output logic                   det_hysteresis_on_out,
  output logic [5:0]             det_level_out,
  output logic                   samp_clk_en_out,
  output logic                   reg_high_drive_out,
  output logic                   reg_normal_out,
  output logic [10:0]            trim_out,
  // system responses
  output logic                   reset_req_out,
  output logic                   irq_out
);

  // register fields
  logic [5:0]          level;        // threshold level
  logic [3:0]          psel;         // prescaler select
  logic                clk_req;      // requested clock
  logic                mode;         // sampled when set
  logic                keep;         // run in standby
  smr_pkg::smr_act_type action;      // drop response
  logic                hysteresis_on;         // hysteresis
  logic                enable;       // detector on
  logic                hdrv;         // regulator drive
  logic                reg_keep;     // regulator standby
  logic [10:0]         trim;         // bandgap trim
  logic [1:0]          status;       // sticky events
  logic [1:0]          ien;          // event enables
  // control state
  logic                preload;      // preload pending
  smr_pkg::smr_ck_type ck_state;     // sampling clock
  logic [2:0]          settle;       // settle counter
  logic                clk_on;       // clock reads on
  logic [31:0]         base_cnt;     // base divider
  logic                base_tick;    // 1 kHz pulse
  logic [15:0]         presc;        // prescaler
  logic                samp_tick;    // sampling pulse
  logic                below_m;      // sync stage 1
  logic                below_s;      // sync stage 2
  logic                drop_q;       // drop seen
  logic                active;       // detector live
  logic                drop_now;     // qualified drop
  logic                drop_evt;     // new drop event
  // bus decode
  logic                wr;           // write strobe
  logic                rd_phase;     // access phase
  logic                mapped;       // known address
  logic [31:0]         rd_val;       // read mux
  logic [15:0]         mask;         // prescaler mask
  logic [1:0]          next_status;  // status update

  // access phase of an apb transfer
  assign rd_phase = psel_in && penable_in && !pready_out;
  assign wr       = rd_phase && pwrite_in && mapped;

  // address decode
  always_comb begin
    case (paddr_in)
      `SMR_DET_OFS, `SMR_REG_OFS, `SMR_REF_OFS,
      `SMR_STAT_OFS, `SMR_CLR_OFS, `SMR_IEN_OFS:
        mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // read data mux, reserved bits zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr_in)
      `SMR_DET_OFS: begin
        rd_val[`SMR_LEVEL_LSB +: 6] = level;
        rd_val[`SMR_PSEL_LSB +: 4]  = psel;
        rd_val[`SMR_CLKON_BIT]      = clk_on;
        rd_val[`SMR_MODE_BIT]       = mode;
        rd_val[`SMR_KEEP_BIT]       = keep;
        rd_val[`SMR_ACT_LSB +: 2]   = action;
        rd_val[`SMR_HYSTERESIS_ON_BIT]       = hysteresis_on;
        rd_val[`SMR_EN_BIT]         = enable;
      end
      `SMR_REG_OFS: begin
        rd_val[`SMR_HDRV_BIT] = hdrv;
        rd_val[`SMR_KEEP_BIT] = reg_keep;
      end
      `SMR_REF_OFS: begin
        rd_val[`SMR_TRIM_LSB +: 11] = trim;
      end
      `SMR_STAT_OFS: begin
        rd_val[1:0] = status;
      end
      `SMR_IEN_OFS: begin
        rd_val[1:0] = ien;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait state, error on unmapped
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= rd_phase;
      pslverr_out <= rd_phase && !mapped;
      if (rd_phase && !pwrite_in) begin
        prdata_out <= rd_val;
      end
    end
  end

  // preload pending flag, cleared one cycle after release
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      preload <= 1'b1;
    end else begin
      preload <= 1'b0;
    end
  end

  // detector control register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      level   <= 6'h00;
      psel    <= 4'h0;
      clk_req <= 1'b0;
      mode    <= 1'b0;
      keep    <= 1'b0;
      action  <= smr_pkg::SMR_ACT_NONE;
      hysteresis_on    <= 1'b0;
      enable  <= 1'b0;
    end else if (preload) begin
      // catch nonvolatile values after release
      level  <= nvm_in.level;
      action <= nvm_in.action;
      hysteresis_on   <= nvm_in.hysteresis_on;
      enable <= nvm_in.enable;
    end else if (wr && paddr_in == `SMR_DET_OFS) begin
      level   <= pwdata_in[`SMR_LEVEL_LSB +: 6];
      psel    <= pwdata_in[`SMR_PSEL_LSB +: 4];
      clk_req <= pwdata_in[`SMR_CLKON_BIT];
      mode    <= pwdata_in[`SMR_MODE_BIT];
      keep    <= pwdata_in[`SMR_KEEP_BIT];
      action  <= smr_pkg::smr_act_type'(pwdata_in[`SMR_ACT_LSB +: 2]);
      hysteresis_on    <= pwdata_in[`SMR_HYSTERESIS_ON_BIT];
      enable  <= pwdata_in[`SMR_EN_BIT];
    end
  end

  // regulator and reference registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hdrv     <= 1'b0;
      reg_keep <= 1'b0;
      trim     <= 11'h000;
    end else if (preload) begin
      trim <= nvm_in.trim;
    end else if (wr && paddr_in == `SMR_REG_OFS) begin
      hdrv     <= pwdata_in[`SMR_HDRV_BIT];
      reg_keep <= pwdata_in[`SMR_KEEP_BIT];
    end else if (wr && paddr_in == `SMR_REF_OFS) begin
      trim <= pwdata_in[`SMR_TRIM_LSB +: 11];
    end
  end

  // sampling clock start and stop with settle time
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ck_state <= smr_pkg::SMR_CK_OFF;
      settle   <= 3'd0;
    end else begin
      case (ck_state)
        smr_pkg::SMR_CK_OFF: begin
          if (clk_req) begin
            ck_state <= smr_pkg::SMR_CK_UP;
            settle   <= 3'(`SMR_SETTLE_CYC - 1);
          end
        end
        smr_pkg::SMR_CK_UP: begin
          if (!clk_req) begin
            ck_state <= smr_pkg::SMR_CK_OFF;
          end else if (settle == 3'd0) begin
            ck_state <= smr_pkg::SMR_CK_ON;
          end else begin
            settle <= settle - 3'd1;
          end
        end
        smr_pkg::SMR_CK_ON: begin
          if (!clk_req) begin
            ck_state <= smr_pkg::SMR_CK_DOWN;
            settle   <= 3'(`SMR_SETTLE_CYC - 1);
          end
        end
        smr_pkg::SMR_CK_DOWN: begin
          if (clk_req) begin
            ck_state <= smr_pkg::SMR_CK_ON;
          end else if (settle == 3'd0) begin
            ck_state <= smr_pkg::SMR_CK_OFF;
          end else begin
            settle <= settle - 3'd1;
          end
        end
        default: ck_state <= smr_pkg::SMR_CK_OFF;
      endcase
    end
  end

  // clock reads one while stable or still stopping
  assign clk_on = (ck_state == smr_pkg::SMR_CK_ON) ||
                  (ck_state == smr_pkg::SMR_CK_DOWN);

  // 1 kHz base enable from the bus clock
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !clk_on) begin
      base_cnt  <= 32'h0000_0000;
      base_tick <= 1'b0;
    end else if (base_cnt == 32'(BASE_CYC - 1)) begin
      base_cnt  <= 32'h0000_0000;
      base_tick <= 1'b1;
    end else begin
      base_cnt  <= base_cnt + 32'h0000_0001;
      base_tick <= 1'b0;
    end
  end

  // prescaler: tick every 2^(psel+1) base ticks
  assign mask = 16'((17'h0_0002 << psel) - 17'h0_0001);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !clk_on) begin
      presc     <= 16'h0000;
      samp_tick <= 1'b0;
    end else begin
      samp_tick <= base_tick && ((presc & mask) == mask);
      if (base_tick) begin
        presc <= presc + 16'h0001;
      end
    end
  end

  // comparator synchroniser
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      below_m <= 1'b0;
      below_s <= 1'b0;
    end else begin
      below_m <= below_in;
      below_s <= below_m;
    end
  end

  // detector live when enabled, unless standby without keep
  assign active = enable && (!standby_in || keep);

  // continuous follows the level; sampled only on ticks
  assign drop_now = mode ? (samp_tick && below_s) : below_s;

  // latch drop so each crossing acts once
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !active) begin
      drop_q <= 1'b0;
    end else if (!mode || samp_tick) begin
      drop_q <= below_s;
    end
  end
  assign drop_evt = active && drop_now && !drop_q;

  // sticky status: set wins over a clear
  always_comb begin
    next_status = status;
    if (wr && paddr_in == `SMR_CLR_OFS) begin
      next_status = status & ~pwdata_in[1:0];
    end
    if (drop_evt && action == smr_pkg::SMR_ACT_IRQ) begin
      next_status[`SMR_ST_DROP] = 1'b1;
    end
    if (ck_state == smr_pkg::SMR_CK_UP && settle == 3'd0
        && clk_req) begin
      next_status[`SMR_ST_CLKUP] = 1'b1;
    end
  end

  // status and interrupt enable registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      status <= 2'b00;
      ien    <= 2'b00;
    end else begin
      status <= next_status;
      if (wr && paddr_in == `SMR_IEN_OFS) begin
        ien <= pwdata_in[1:0];
      end
    end
  end

  // system responses; reserved action does nothing
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reset_req_out <= 1'b0;
      irq_out       <= 1'b0;
    end else begin
      reset_req_out <= drop_evt && action == smr_pkg::SMR_ACT_RST;
      irq_out       <= |(next_status & ien);
    end
  end

  // analog control outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      det_on_out         <= 1'b0;
      det_hysteresis_on_out       <= 1'b0;
      det_level_out      <= 6'h00;
      samp_clk_en_out    <= 1'b0;
      reg_high_drive_out <= 1'b0;
      reg_normal_out     <= 1'b0;
      trim_out           <= 11'h000;
    end else begin
      det_on_out         <= active;
      det_hysteresis_on_out       <= hysteresis_on;
      // level is expected stable while disabled
      det_level_out      <= level;
      samp_clk_en_out    <= clk_req;
      reg_high_drive_out <= standby_in && hdrv;
      reg_normal_out     <= !standby_in || reg_keep;
      trim_out           <= trim;
    end
  end

endmodule : smr_top

/* hdl/smr_params.svh */
`ifndef SMR_PARAMS_SVH
`define SMR_PARAMS_SVH
// register byte offsets
`define SMR_DET_OFS    8'h34
`define SMR_REG_OFS    8'h3c
`define SMR_REF_OFS    8'h40
`define SMR_STAT_OFS   8'h44
`define SMR_CLR_OFS    8'h48
`define SMR_IEN_OFS    8'h4c
// detector control fields
`define SMR_LEVEL_LSB  16
`define SMR_PSEL_LSB   12
`define SMR_CLKON_BIT  9
`define SMR_MODE_BIT   8
`define SMR_KEEP_BIT   6
`define SMR_ACT_LSB    3
`define SMR_HYSTERESIS_ON_BIT   2
`define SMR_EN_BIT     1
// regulator and reference fields
`define SMR_HDRV_BIT   13
`define SMR_TRIM_LSB   16
// status bits
`define SMR_ST_DROP    0
`define SMR_ST_CLKUP   1
// reset values before the preload
`define SMR_DET_RST    32'h0000_0000
`define SMR_REG_RST    16'h0000
// sampling clock settle time
`define SMR_SETTLE_NS  40
`define SMR_CLK_NS     10
`define SMR_SETTLE_CYC ((`SMR_SETTLE_NS + `SMR_CLK_NS - 1) / `SMR_CLK_NS)
// slow sampling base period (1 kHz)
`define SMR_BASE_NS    1000000
`define SMR_BASE_CYC   (`SMR_BASE_NS / `SMR_CLK_NS)
`endif

/* hdl/smr_pkg.sv */
package smr_pkg;
  // detector action encodings
  typedef enum logic [1:0] {
    SMR_ACT_NONE = 2'b00,
    SMR_ACT_RST  = 2'b01,
    SMR_ACT_IRQ  = 2'b10,
    SMR_ACT_RSVD = 2'b11
  } smr_act_type;
  // sampling clock states
  typedef enum logic [1:0] {
    SMR_CK_OFF  = 2'b00,
    SMR_CK_UP   = 2'b01,
    SMR_CK_ON   = 2'b10,
    SMR_CK_DOWN = 2'b11
  } smr_ck_type;
  // values preloaded from the nonvolatile rows
  typedef struct packed {
    logic [5:0]  level;
    smr_act_type action;
    logic        hysteresis_on;
    logic        enable;
    logic [10:0] trim;
  } smr_nvm_type;
endpackage : smr_pkg

/* sim/smr_top_assertions.sv */
`timescale 1ns/10ps
`include "smr_params.svh"
// port-level checks of the supply monitor block
module smr_top_chk (
  // clock, reset and bus
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  // power state and controls
  input wire logic        standby_in,
  input wire logic        below_in,
  input wire logic        det_hysteresis_on_out,
  input wire logic        samp_clk_en_out,
  input wire logic        reg_high_drive_out,
  input wire logic        reg_normal_out,
  input wire logic [10:0] trim_out,
  input wire logic        reset_req_out,
  input wire logic        irq_out
);
  logic       wr_go;  // write taken at this edge
  logic       wr_ref; // write to the reference register
  logic [1:0] up_cnt; // edges since reset release
  assign wr_go  = psel_in && penable_in && pwrite_in && !pready_out;
  assign wr_ref = wr_go && paddr_in == `SMR_REF_OFS;
  // saturating count keeps the preload edges out of the checks
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // write taken on one offset
  sequence s_wr(logic [7:0] ofs);
    wr_go && paddr_in == ofs;
  endsequence
  // reset request lasts one cycle
  sequence s_pulse;
    reset_req_out ##1 !reset_req_out;
  endsequence
  apb_wait_a:
    assert property (psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
      else $error("pready missing after one wait state");
  clk_bit_a:
    assert property (s_wr(`SMR_DET_OFS) |-> ##2
      samp_clk_en_out == $past(pwdata_in[`SMR_CLKON_BIT], 2))
      else $error("clock request does not follow the write");
  hysteresis_on_bit_a:
    assert property (s_wr(`SMR_DET_OFS) ##2 1'h1 |->
      det_hysteresis_on_out == $past(pwdata_in[`SMR_HYSTERESIS_ON_BIT], 2))
      else $error("hysteresis does not follow the write");
  rst_pulse_a:
    assert property ($rose(reset_req_out) |-> $past(below_in, 3) ##0 s_pulse)
      else $error("reset request without a drop or too long");
  hd_standby_a:
    assert property (reg_high_drive_out |-> $past(standby_in))
      else $error("high drive outside standby");
  norm_awake_a:
    assert property (up_cnt == 2'h3 && !$past(standby_in) |-> reg_normal_out)
      else $error("regulator not normal while awake");
  irq_mask_a:
    assert property (s_wr(`SMR_IEN_OFS) ##0 pwdata_in == 32'h0000_0000 |-> ##2 !irq_out)
      else $error("interrupt stays up after masking");
  trim_hold_a:
    assert property ($changed(trim_out) && up_cnt == 2'h3 |-> $past(wr_ref) || $past(wr_ref, 2))
      else $error("trim changed without a write");
endmodule : smr_top_chk

/* sim/smr_top_tb.sv */
`timescale 1ns/10ps
`include "smr_params.svh"
// self-checking bench for the supply monitor block
module smr_top_tb;
  // table row: write, read back, expected outputs
  typedef struct packed {
    logic [7:0]  a; // byte address
    logic [31:0] d; // write data
    logic [31:0] r; // expected read data
    logic        e; // expected slave error
    logic [7:0]  o; // enable, hysteresis, level
    logic [10:0] t; // trim
  } smr_row_type;
  // design ports
  logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  smr_pkg::smr_nvm_type nvm_in;
  logic standby_in, below_in, det_on_out, det_hysteresis_on_out, samp_clk_en_out;
  logic reg_high_drive_out, reg_normal_out, reset_req_out, irq_out;
  logic [5:0]  det_level_out;
  logic [10:0] trim_out;
  // bench state
  int          errors = 0;
  int          n_compared = 0;
  int          n_rst = 0; // reset requests seen
  logic [31:0] q;
  logic        e;
  logic [1:0]  acts [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  smr_row_type rows [8] = '{
    '{`SMR_DET_OFS, 32'hffff_fdff, 32'h003f_f15e, 1'h0, 8'hff, 11'h5a5},
    '{`SMR_REF_OFS, 32'hffff_ffff, 32'h07ff_0000, 1'h0, 8'hff, 11'h7ff},
    '{`SMR_REG_OFS, 32'h0000_2040, 32'h0000_2040, 1'h0, 8'hff, 11'h7ff},
    '{`SMR_IEN_OFS, 32'h0000_0003, 32'h0000_0003, 1'h0, 8'hff, 11'h7ff},
    '{`SMR_STAT_OFS, 32'hffff_ffff, 32'h0000_0000, 1'h0, 8'hff, 11'h7ff},
    '{8'h50, 32'hffff_ffff, 32'h0000_0000, 1'h1, 8'hff, 11'h7ff},
    '{`SMR_DET_OFS, 32'h003f_0000, 32'h003f_0000, 1'h0, 8'h3f, 11'h7ff},
    '{`SMR_REF_OFS, 32'h0000_0000, 32'h0000_0000, 1'h0, 8'h3f, 11'h000}};
  // design under test with a short sampling base
  smr_top #(.BASE_CYC(4)) dut_u (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .nvm_in, .standby_in,
    .below_in, .det_on_out, .det_hysteresis_on_out, .det_level_out, .samp_clk_en_out,
    .reg_high_drive_out, .reg_normal_out, .trim_out, .reset_req_out, .irq_out);
  // one transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in    <= 1'h1;
    penable_in <= 1'h0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_in);
    penable_in <= 1'h1;
    do @(posedge clk_in); while (pready_out !== 1'h1);
    q = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'h0;
    penable_in <= 1'h0;
  endtask : apb
  // compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // comparator high for n cycles, then settle
  task automatic drop(input int n);
    n_rst = 0;
    below_in <= 1'h1;
    repeat (n) @(posedge clk_in);
    below_in <= 1'h0;
    repeat (8) @(posedge clk_in);
  endtask : drop
  // verdict and end of run
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // clock and pulse counter
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (reset_req_out === 1'h1) n_rst++;
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    $display("mismatch watchdog expected done seen hang");
    finish_test();
  end
  // main sequence
  initial begin
    {rst_n_in, psel_in, penable_in, pwrite_in, standby_in, below_in} = 6'h00;
    paddr_in = 8'h00;
    pwdata_in = 32'h0000_0000;
    nvm_in = '{6'h15, smr_pkg::SMR_ACT_RST, 1'h1, 1'h0, 11'h5a5};
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    apb(1'h0, `SMR_DET_OFS, 32'h0000_0000);
    chk("det preload", q, 32'h0015_000c);
    apb(1'h0, `SMR_REF_OFS, 32'h0000_0000);
    chk("ref preload", q, 32'h05a5_0000);
    chk("outs preload", {det_on_out, det_hysteresis_on_out, det_level_out, trim_out}, 19'h2_ada5);
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].d);
      apb(1'h0, rows[i].a, 32'h0000_0000);
      chk("row read", q, rows[i].r);
      chk("row error", e, rows[i].e);
      chk("row outs", {det_on_out, det_hysteresis_on_out, det_level_out, trim_out}, {rows[i].o, rows[i].t});
    end
    // each action code on a supply drop
    apb(1'h1, `SMR_IEN_OFS, 32'h0000_0001);
    foreach (acts[k]) begin
      apb(1'h1, `SMR_CLR_OFS, 32'h0000_0003);
      apb(1'h1, `SMR_DET_OFS, {27'h000_0000, acts[k], 3'h2});
      drop(6);
      apb(1'h0, `SMR_STAT_OFS, 32'h0000_0000);
      chk("drop status", q[0], acts[k] == 2'h2);
      chk("drop reset", n_rst, acts[k] == 2'h1);
      chk("drop irq", irq_out, acts[k] == 2'h2);
    end
    // mask, unmask and clear the interrupt
    apb(1'h1, `SMR_IEN_OFS, 32'h0000_0000);
    repeat (3) @(posedge clk_in);
    chk("irq masked", irq_out, 1'h0);
    apb(1'h1, `SMR_IEN_OFS, 32'h0000_0001);
    repeat (3) @(posedge clk_in);
    chk("irq unmasked", irq_out, 1'h1);
    apb(1'h1, `SMR_CLR_OFS, 32'h0000_0001);
    repeat (3) @(posedge clk_in);
    chk("irq cleared", irq_out, 1'h0);
    // standby without and with the keep bits
    apb(1'h1, `SMR_DET_OFS, 32'h0000_000a);
    apb(1'h1, `SMR_REG_OFS, 32'h0000_2000);
    standby_in <= 1'h1;
    drop(6);
    chk("standby off", {det_on_out, reg_high_drive_out, reg_normal_out, n_rst[0]}, 4'h4);
    apb(1'h1, `SMR_DET_OFS, 32'h0000_0042);
    apb(1'h1, `SMR_REG_OFS, 32'h0000_0040);
    repeat (3) @(posedge clk_in);
    chk("standby keep", {det_on_out, reg_high_drive_out, reg_normal_out}, 3'h5);
    standby_in <= 1'h0;
    // sampling clock start and stop readback
    apb(1'h1, `SMR_DET_OFS, 32'h0000_0200);
    apb(1'h0, `SMR_DET_OFS, 32'h0000_0000);
    chk("clk early", {samp_clk_en_out, q[9]}, 2'h2);
    repeat (10) @(posedge clk_in);
    apb(1'h0, `SMR_DET_OFS, 32'h0000_0000);
    chk("clk stable", q[9], 1'h1);
    apb(1'h0, `SMR_STAT_OFS, 32'h0000_0000);
    chk("clk status", q[1], 1'h1);
    apb(1'h1, `SMR_DET_OFS, 32'h0000_0000);
    apb(1'h0, `SMR_DET_OFS, 32'h0000_0000);
    chk("clk late", {samp_clk_en_out, q[9]}, 2'h1);
    repeat (10) @(posedge clk_in);
    apb(1'h0, `SMR_DET_OFS, 32'h0000_0000);
    chk("clk stopped", q[9], 1'h0);
    // sampled mode needs a running clock
    apb(1'h1, `SMR_DET_OFS, 32'h0000_010a);
    drop(20);
    chk("sampled idle", n_rst, 0);
    apb(1'h1, `SMR_DET_OFS, 32'h0000_030a);
    repeat (10) @(posedge clk_in);
    drop(20);
    chk("sampled tick", n_rst, 1);
    // a second reset clears the outputs
    rst_n_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    chk("reset outs", {pready_out, irq_out, det_on_out, samp_clk_en_out, trim_out}, 0);
    // release again: the preload must repeat
    rst_n_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    apb(1'h0, `SMR_DET_OFS, 32'h0000_0000);
    chk("det reload", q, 32'h0015_000c);
    finish_test();
  end
endmodule : smr_top_tb
// checker on the top ports
bind smr_top smr_top_chk chk_u (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .pready_out, .standby_in, .below_in, .det_hysteresis_on_out,
  .samp_clk_en_out, .reg_high_drive_out, .reg_normal_out, .trim_out, .reset_req_out, .irq_out);
